// >>> hdl/channel_power_control_regs.sv
// Page 0 channel enable, output slot, power configuration and status registers.
// Assumes a synchronous 8-bit host register port, one access per strobe.
`timescale 1ns/100ps

module channel_power_control_regs
   import cpc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Host register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   // Audio serial port slot timing
   input wire logic slotActive,
   input wire logic [1:0] slotIndex,
   input wire logic slotData,
   output logic sdOut,
   output logic sdOutEnN,
   // Analog and detector power controls
   output logic micBiasPower,
   output logic synthPower,
   output logic voiceDetectOn,
   output logic [3:0] chanPowerOn,
   output logic [3:0] chanPowered
);
   logic [7:0] page_ff;
   logic [7:0] inEn_ff;
   logic [7:0] slotEn_ff;
   logic [7:0] pwrCfg_ff;
   logic [3:0] want_ff;
   logic [3:0] nxt_want;
   logic [3:0] seqPowered;
   logic [3:0] enabled;
   logic [3:0] inRange;
   logic recording;
   logic onPage0;
   logic wrPage;
   logic wrInEn;
   logic wrSlotEn;
   logic wrPwrCfg;
   logic [7:0] statusByte;
   logic [7:0] rdByte;

   // Page 0 access check, used for the write strobes only
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs,
                                input logic [7:0] page);
      hit = (addr == ofs) && (page == REG_PAGE);
   endfunction

   assign onPage0 = (page_ff == REG_PAGE);

   // Write strobes, one per register. The status offset has no strobe, so a
   // host write there is dropped rather than stored; bank strobes also need
   // page zero, so a write on another page cannot land in the bank.
   assign wrPage = regWrite && (regAddr == PAGE_SELECT_OFS);
   assign wrInEn = regWrite && hit(regAddr, INPUT_CHANNEL_ENABLE_OFS, page_ff);
   assign wrSlotEn = regWrite && hit(regAddr, OUTPUT_SLOT_ENABLE_OFS, page_ff);
   assign wrPwrCfg = regWrite && hit(regAddr, POWER_CONFIGURATION_OFS, page_ff);

   ////////////////////////////////////////////////////////////////////////////
   // Page select is reachable on every page. Any value is stored, and every
   // page but zero hides the bank below, for reads and writes alike.
   // The host must come back to page zero before touching the bank.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         page_ff <= PAGE_SELECT_RST;
      end else if (wrPage) begin
         page_ff <= regWdata;
      end
   end

   // Input enables; reserved low nibble is masked so it stays zero
   // Channels three and four only ever feed digital microphone inputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         inEn_ff <= INPUT_CHANNEL_ENABLE_RST;
      end else if (wrInEn) begin
         inEn_ff <= regWdata & INPUT_CHANNEL_ENABLE_MASK;
      end
   end

   // Output slot enables
   // A cleared bit keeps that slot undriven on the data pin
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         slotEn_ff <= OUTPUT_SLOT_ENABLE_RST;
      end else if (wrSlotEn) begin
         slotEn_ff <= regWdata & OUTPUT_SLOT_ENABLE_MASK;
      end
   end

   // Power configuration; reserved bit 1 never stores
   // Range codes two and three are kept as written; the decode below tames them
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pwrCfg_ff <= POWER_CONFIGURATION_RST;
      end else if (wrPwrCfg) begin
         pwrCfg_ff <= regWdata & POWER_CONFIGURATION_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel request decode; bit 0 of every channel vector is channel one,
   // the reverse of the register, which keeps channel one in the top bit
   assign enabled = {inEn_ff[INPUT_FOUR_ON_BIT], inEn_ff[INPUT_THREE_ON_BIT],
                     inEn_ff[INPUT_TWO_ON_BIT], inEn_ff[INPUT_ONE_ON_BIT]};

   // A channel counts as recording from the moment it is requested, not from
   // the end of its power-up, so a half-finished sequence is not disturbed
   assign recording = |want_ff;

   // Configuration fields by name, so the request logic reads plainly
   logic convOn;
   logic dynSwitch;
   logic [1:0] rangeCode;

   assign convOn = pwrCfg_ff[CONVERTER_POWER_BIT];
   assign dynSwitch = pwrCfg_ff[DYNAMIC_POWER_SWITCH_ON_BIT];
   assign rangeCode = pwrCfg_ff[DYNAMIC_CHANNEL_RANGE_LSB +: 2];

   // Range field limits which channels may switch alone. The host must not
   // program codes two and three; should it do so anyway, they act like the
   // two-channel code, so channels three and four stay frozen rather than
   // switching on a guess.
   always_comb begin
      unique case (rangeCode)
         RANGE_FOUR_CHANNELS: inRange = 4'hf;
         default: inRange = 4'h3;
      endcase
   end

   // Requested channel power. With the converter bit clear every channel is
   // dropped at once. While nothing records, requests simply follow the
   // enables. Once recording, only the dynamic bit lets channels move, and
   // then only those inside the range; without it, an enable change made
   // while recording waits until the converter bit is cycled.
   always_comb begin
      nxt_want = want_ff;
      if (!convOn) begin
         nxt_want = 4'h0;
      end else if (!recording) begin
         nxt_want = enabled;
      end else if (dynSwitch) begin
         nxt_want = (enabled & inRange) | (want_ff & ~inRange);
      end else begin
         nxt_want = want_ff;
      end
   end

   // Request register; all channels start unrequested whatever the enables say
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         want_ff <= 4'h0;
      end else begin
         want_ff <= nxt_want;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One power sequencer per channel. Each runs alone, so channels that are
   // requested together finish together, and a late one does not hold back
   // the others.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gChan
         cpc_chan_seq uSeq (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .want(want_ff[gi]),
            .powered(seqPowered[gi])
         );
      end
   endgenerate

   // Slot drive on the serial data pin; only the top nibble of the slot
   // register carries enables, the reserved nibble is never looked at
   cpc_slot_drive uSlot (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .slotDrive(slotEn_ff[7:4]),
      .slotActive(slotActive),
      .slotIndex(slotIndex),
      .slotData(slotData),
      .sdOut(sdOut),
      .sdOutEnN(sdOutEnN)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registered power outputs, one block per control. Each lags the flop it copies
   // (a config bit, want_ff or seqPowered) by one cycle, so the analog side never sees a decode glitch.

   // Microphone bias generator power
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         micBiasPower <= 1'b0;
      end else begin
         micBiasPower <= pwrCfg_ff[MIC_BIAS_POWER_BIT];
      end
   end

   // Synthesizer power; nothing here waits for it to settle, that is left
   // to whoever owns the clock tree
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         synthPower <= 1'b0;
      end else begin
         synthPower <= pwrCfg_ff[SYNTH_POWER_BIT];
      end
   end

   // Voice detector enable
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         voiceDetectOn <= 1'b0;
      end else begin
         voiceDetectOn <= pwrCfg_ff[VOICE_DETECT_ON_BIT];
      end
   end

   // Per-channel power request towards the converters
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         chanPowerOn <= 4'h0;
      end else begin
         chanPowerOn <= want_ff;
      end
   end

   // Completed power state per channel; lags the request by a whole sequence
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         chanPowered <= 4'h0;
      end else begin
         chanPowered <= seqPowered;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status byte: only channels one and two have a place in the register,
   // channels three and four show on chanPowered alone
   always_comb begin
      statusByte = CHANNEL_POWER_STATUS_RST;
      statusByte[CHAN_ONE_POWERED_BIT] = seqPowered[0];
      statusByte[CHAN_TWO_POWERED_BIT] = seqPowered[1];
   end

   // Read-back selection. Page select answers on every page, the bank only
   // on page zero; unmapped offsets give zero rather than stale data, so a
   // stray read cannot be mistaken for a register.
   always_comb begin
      rdByte = 8'h00;
      if (regAddr == PAGE_SELECT_OFS) begin
         rdByte = page_ff;
      end else if (onPage0) begin
         case (regAddr)
            INPUT_CHANNEL_ENABLE_OFS: begin
               rdByte = inEn_ff;
            end
            OUTPUT_SLOT_ENABLE_OFS: begin
               rdByte = slotEn_ff;
            end
            POWER_CONFIGURATION_OFS: begin
               rdByte = pwrCfg_ff;
            end
            CHANNEL_POWER_STATUS_OFS: begin
               rdByte = statusByte;
            end
            default: begin
               rdByte = 8'h00;
            end
         endcase
      end else begin
         rdByte = 8'h00;
      end
   end

   // Read data, one cycle after the read strobe, held until the next read so
   // a slow host may pick it up late
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         regRdata <= rdByte;
      end
   end
endmodule

// >>> hdl/cpc_chan_seq.sv
// Power sequencer for one converter channel.
// Assumes want is a level from the register logic in the clk_sys domain.
`timescale 1ns/100ps
module cpc_chan_seq
   import cpc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Control
   input wire logic want,
   // Status
   output logic powered
);
   cpc_chan_e state_ff;
   cpc_chan_e nxt_state;
   logic [SEQ_CNT_W-1:0] cnt_ff;
   logic cntDone;

   assign cntDone = (cnt_ff == SEQ_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // State choice; a reversed request mid-sequence turns round at once
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         CPC_OFF: begin
            if (want) begin
               nxt_state = CPC_RISE;
            end
         end
         CPC_RISE: begin
            if (!want) begin
               nxt_state = CPC_FALL;
            end else if (cntDone) begin
               nxt_state = CPC_ON;
            end
         end
         CPC_ON: begin
            if (!want) begin
               nxt_state = CPC_FALL;
            end
         end
         CPC_FALL: begin
            if (want) begin
               nxt_state = CPC_RISE;
            end else if (cntDone) begin
               nxt_state = CPC_OFF;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff <= CPC_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Sequence timer restarts on every state change
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
      end else if (nxt_state != state_ff) begin
         cnt_ff <= '0;
      end else if (!cntDone) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // Status follows only a completed sequence
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         powered <= 1'b0;
      end else if (state_ff == CPC_RISE && nxt_state == CPC_ON) begin
         powered <= 1'b1;
      end else if (state_ff == CPC_FALL && nxt_state == CPC_OFF) begin
         powered <= 1'b0;
      end
   end
endmodule

// >>> hdl/cpc_pkg.sv
// Package for the channel power control register bank.
// Assumes an 8-bit host register port with page select at offset 0.
package cpc_pkg;
   // Register offsets on page 0
   localparam logic [7:0] PAGE_SELECT_OFS = 8'h00;
   localparam logic [7:0] INPUT_CHANNEL_ENABLE_OFS = 8'h73;
   localparam logic [7:0] OUTPUT_SLOT_ENABLE_OFS = 8'h74;
   localparam logic [7:0] POWER_CONFIGURATION_OFS = 8'h75;
   localparam logic [7:0] CHANNEL_POWER_STATUS_OFS = 8'h76;
   localparam logic [7:0] REG_PAGE = 8'h00;
   // Reset values
   localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
   localparam logic [7:0] INPUT_CHANNEL_ENABLE_RST = 8'hc0;
   localparam logic [7:0] OUTPUT_SLOT_ENABLE_RST = 8'h00;
   localparam logic [7:0] POWER_CONFIGURATION_RST = 8'h00;
   localparam logic [7:0] CHANNEL_POWER_STATUS_RST = 8'h00;
   // Writable bit masks; every other bit is reserved and reads zero
   localparam logic [7:0] INPUT_CHANNEL_ENABLE_MASK = 8'hf0;
   localparam logic [7:0] OUTPUT_SLOT_ENABLE_MASK = 8'hf0;
   localparam logic [7:0] POWER_CONFIGURATION_MASK = 8'hfd;
   // Field positions
   localparam int INPUT_ONE_ON_BIT = 7;
   localparam int INPUT_TWO_ON_BIT = 6;
   localparam int INPUT_THREE_ON_BIT = 5;
   localparam int INPUT_FOUR_ON_BIT = 4;
   localparam int SLOT_ONE_DRIVE_BIT = 7;
   localparam int MIC_BIAS_POWER_BIT = 7;
   localparam int CONVERTER_POWER_BIT = 6;
   localparam int SYNTH_POWER_BIT = 5;
   localparam int DYNAMIC_POWER_SWITCH_ON_BIT = 4;
   localparam int DYNAMIC_CHANNEL_RANGE_LSB = 2;
   localparam int VOICE_DETECT_ON_BIT = 0;
   localparam int CHAN_ONE_POWERED_BIT = 7;
   localparam int CHAN_TWO_POWERED_BIT = 6;
   // Range codes
   localparam logic [1:0] RANGE_TWO_CHANNELS = 2'h0;
   localparam logic [1:0] RANGE_FOUR_CHANNELS = 2'h1;
   // Power sequence length per channel, in clk_sys cycles
   localparam int SEQ_TIME_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SEQ_CYCLES = (SEQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEQ_CNT_W = 8;
   localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = 8'(SEQ_CYCLES - 1);
   // Channel power sequencer states
   typedef enum logic [1:0] {
      CPC_OFF = 2'b00,
      CPC_RISE = 2'b01,
      CPC_ON = 2'b10,
      CPC_FALL = 2'b11
   } cpc_chan_e;
endpackage

// >>> hdl/cpc_slot_drive.sv
// Output slot driver for the audio serial port data pin.
// Assumes slot index and slot data come from the serial framing logic.
`timescale 1ns/100ps
module cpc_slot_drive
   import cpc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Slot control
   input wire logic [3:0] slotDrive,
   input wire logic slotActive,
   input wire logic [1:0] slotIndex,
   input wire logic slotData,
   // Pin
   output logic sdOut,
   output logic sdOutEnN
);
   ////////////////////////////////////////////////////////////////////////////
   // Slot 0 maps to bit 3 of slotDrive, which holds channel one
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sdOut <= 1'b0;
         sdOutEnN <= 1'b1;
      end else begin
         sdOut <= slotData;
         sdOutEnN <= !(slotActive && slotDrive[2'd3 - slotIndex]);
      end
   end
endmodule

// >>> verification/channel_power_control_regs_tb_top.sv
// Self-checking bench for the channel power register bank.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/100ps
module channel_power_control_regs_tb_top import cpc_pkg::*;;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic slotActive = 1'b0;
   logic [1:0] slotIndex = 2'h0;
   logic slotData = 1'b0;
   logic [7:0] regRdata;
   logic sdOut, sdOutEnN, micBiasPower, synthPower, voiceDetectOn;
   logic [3:0] chanPowerOn, chanPowered;
   logic [7:0] expQ[$];
   logic rdSeen = 1'b0;
   logic [7:0] v;
   int mismatches = 0;
   int checked = 0;
   channel_power_control_regs uut (.clk_sys(clk_sys), .rstn(rstn), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .slotActive(slotActive), .slotIndex(slotIndex), .slotData(slotData), .sdOut(sdOut),
      .sdOutEnN(sdOutEnN), .micBiasPower(micBiasPower), .synthPower(synthPower),
      .voiceDetectOn(voiceDetectOn), .chanPowerOn(chanPowerOn), .chanPowered(chanPowered));
   // 100 MHz clock
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // One write; the strobe drops a cycle later, so calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   // One read; the expected byte waits in the queue for the monitor
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= a;
      expQ.push_back(e);
      @(posedge clk_sys);
      regRead <= 1'b0;
   endtask
   task automatic waitPow(input logic [3:0] e);
      int n;
      n = 0;
      while (chanPowered !== e && n < 400) begin
         cyc(1);
         n++;
      end
      chk("chanPowered", 8'(e), 8'(chanPowered));
   endtask
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Read data lands one cycle after the read edge
   always @(posedge clk_sys) begin
      if (rdSeen) begin
         chk("regRdata", expQ.pop_front(), regRdata);
      end
      rdSeen <= regRead;
   end
   // Watchdog, far beyond the several hundred cycles the tests need
   initial begin
      #200000;
      mismatches++;
      report_and_stop;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      v = 8'($urandom(58924));
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(8'h73, 8'hc0);
      rd(8'h74, 8'h00);
      rd(8'h75, 8'h00);
      rd(8'h76, 8'h00);
      chk("sdOutEnN", 8'h01, 8'(sdOutEnN));
      $display("test reset done");
      // Host writes reserved bits as zero and range codes 0 or 1 only
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom);
         wr(8'h73, v & 8'hf0);
         rd(8'h73, v & 8'hf0);
         wr(8'h74, v & 8'hf0);
         rd(8'h74, v & 8'hf0);
         wr(8'h75, v & 8'hf5);
         rd(8'h75, v & 8'hf5);
         cyc(3);
         chk("micBiasPower", 8'(v[7]), 8'(micBiasPower));
         chk("synthPower", 8'(v[5]), 8'(synthPower));
         chk("voiceDetectOn", 8'(v[0]), 8'(voiceDetectOn));
      end
      wr(8'h75, 8'h00);
      waitPow(4'h0);
      $display("test fields done");
      wr(8'h73, 8'hc0);
      wr(8'h00, 8'h01);
      rd(8'h00, 8'h01);
      rd(8'h73, 8'h00);
      wr(8'h73, 8'h30);
      wr(8'h00, 8'h00);
      rd(8'h73, 8'hc0);
      $display("test page done");
      wr(8'h75, 8'h40);
      cyc(3);
      chk("chanPowerOn", 8'h03, 8'(chanPowerOn));
      cyc(20);
      chk("chanPowered", 8'h00, 8'(chanPowered));
      waitPow(4'h3);
      rd(8'h76, 8'hc0);
      wr(8'h73, 8'h80);
      cyc(3);
      chk("chanPowerOn", 8'h03, 8'(chanPowerOn));
      wr(8'h75, 8'h50);
      cyc(3);
      chk("chanPowerOn", 8'h01, 8'(chanPowerOn));
      waitPow(4'h1);
      rd(8'h76, 8'h80);
      wr(8'h73, 8'hf0);
      wr(8'h75, 8'h54);
      cyc(3);
      chk("chanPowerOn", 8'h0f, 8'(chanPowerOn));
      wr(8'h75, 8'h00);
      cyc(4);
      chk("chanPowerOn", 8'h00, 8'(chanPowerOn));
      waitPow(4'h0);
      wr(8'h76, 8'hc0);
      rd(8'h76, 8'h00);
      $display("test power done");
      wr(8'h74, 8'ha0);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         @(posedge clk_sys);
         slotActive <= 1'b1;
         slotIndex <= 2'(i);
         slotData <= v[0];
         cyc(1);
         chk("sdOutEnN", 8'(i % 2), 8'(sdOutEnN));
         if (i % 2 == 0) chk("sdOut", 8'(v[0]), 8'(sdOut));
      end
      @(posedge clk_sys);
      slotActive <= 1'b0;
      cyc(1);
      chk("sdOutEnN", 8'h01, 8'(sdOutEnN));
      $display("test slots done");
      report_and_stop;
   end
endmodule

// >>> verification/cpc_regs_chk.sv
// Checker for the channel power register bank, on its ports only.
// Assumes a single clk_sys domain and rstn asynchronous, active low.
`timescale 1ns/100ps
module cpc_regs_chk
   import cpc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Host port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   // Slot timing input, pin and power outputs
   input wire logic slotActive,
   input wire logic sdOutEnN,
   input wire logic micBiasPower,
   input wire logic synthPower,
   input wire logic voiceDetectOn,
   input wire logic [3:0] chanPowerOn,
   input wire logic [3:0] chanPowered
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic pageZero_ff;
   logic [7:0] cfg_ff;
   logic wrCfg;
   logic rdBank;
   ////////////////////////////////////////////////////////////
   // Page and configuration mirrors, so gating can be judged
   assign wrCfg = regWrite && regAddr == 8'h75 && pageZero_ff;
   assign rdBank = regRead && regAddr inside {[8'h73:8'h76]};
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pageZero_ff <= 1'b1;
      end else if (regWrite && regAddr == 8'h00) begin
         pageZero_ff <= (regWdata == 8'h00);
      end
   end
   // Configuration copy, updated only by accepted writes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg_ff <= 8'h00;
      end else if (wrCfg) begin
         cfg_ff <= regWdata;
      end
   end
   ////////////////////////////////////////////////////////////
   // Properties
   chk_slot_idle_tristate: assert property (!slotActive |=> sdOutEnN)
      else $error("slot driven outside an active slot");
   chk_rise_after_seq: assert property (
      $rose(chanPowerOn[0]) && !chanPowered[0] |=> !chanPowered[0] [*8])
      else $error("status rose before power sequence");
   chk_fall_after_seq: assert property (
      $fell(chanPowerOn[0]) && chanPowered[0] |=> chanPowered[0] [*8])
      else $error("status fell before power sequence");
   chk_cfg_drives_out: assert property (
      wrCfg |-> ##[1:3] (micBiasPower == cfg_ff[7]
      && synthPower == cfg_ff[5] && voiceDetectOn == cfg_ff[0]))
      else $error("power control outputs do not follow config");
   chk_conv_all_off: assert property (
      wrCfg && !regWdata[6] |-> ##[1:4] chanPowerOn == 4'h0)
      else $error("channel still requested with converter off");
   chk_status_read: assert property (
      regRead && regAddr == 8'h76 && pageZero_ff
      |=> regRdata == {chanPowered[0], chanPowered[1], 6'h00})
      else $error("status read does not match power state");
   chk_page_gate: assert property (rdBank && !pageZero_ff |=> regRdata == 8'h00)
      else $error("bank readable off page zero");
   chk_reserved_zero: assert property (
      regRead && regAddr inside {8'h73, 8'h74} |=> regRdata[3:0] == 4'h0)
      else $error("reserved bits read nonzero");
   cover property ($rose(chanPowered[0]));
   cover property (!sdOutEnN);
   cover property (rdBank && !pageZero_ff);
endmodule
bind channel_power_control_regs cpc_regs_chk chk (.clk_sys(clk_sys), .rstn(rstn),
   .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .slotActive(slotActive), .sdOutEnN(sdOutEnN),
   .micBiasPower(micBiasPower), .synthPower(synthPower), .voiceDetectOn(voiceDetectOn),
   .chanPowerOn(chanPowerOn), .chanPowered(chanPowered));
